//--- hdl/rtcb_cfg.svh
// Constants for the circular ring buffer logic of the remote terminal
// Overview of operation
// - Ring mode only with pingpong and mode-two clear
// - Mode code commands never use the ring
// - Descriptor: control, start, current, end pointers
// - Start and end pointers are never rewritten
// - Descriptor chosen by T/R and subaddress only
// - Receive data starts at current pointer plus two
// - Info and time tag written after receive completes
// - Transmit fetch from current plus two, then info
// - Good receive advances pointer or wraps to start
// - Receive wrap raises interrupt when both enables set
// - Good transmit advances pointer or wraps, interrupt
// - Failed messages keep pointer, still write info
// - Wrap decided after completion, overrun allowed during
// - Broadcast data shares the ring regardless of config
// - Extended config bit marks broadcast in info word
// - Broadcast transmit writes info, pointer unchanged
`ifndef RTCB_CFG_SVH
`define RTCB_CFG_SVH

// ****************************************
// Register map
// ****************************************
`define RTCB_REG_IRQ_EN 8'h12
`define RTCB_REG_CONFIG 8'h17
`define RTCB_REG_EXT 8'h4D
`define RTCB_REG_RESET 16'h0000
`define RTCB_EXT_BROADCAST_FLAG_BIT 3
`define RTCB_IE_BLKDONE_BIT 15

// ****************************************
// Descriptor layout
// ****************************************
`define RTCB_DESC_BASE 16'h0400
`define RTCB_DW_CTRL 2'h0
`define RTCB_DW_START 2'h1
`define RTCB_DW_CUR 2'h2
`define RTCB_DW_END 2'h3
`define RTCB_CW_PINGPONG_BIT 0
`define RTCB_CW_MODE1_BIT 1
`define RTCB_CW_MODE2_BIT 2
`define RTCB_CW_BLKDONE_BIT 15

// ****************************************
// Record layout and command word
// ****************************************
`define RTCB_OFS_TTAG 16'h0001
`define RTCB_OFS_DATA 16'h0002
`define RTCB_STEP 16'h0001
`define RTCB_INFO_BROADCAST_FLAG_BIT 9
`define RTCB_CMD_RT_HI 15
`define RTCB_CMD_RT_LO 11
`define RTCB_CMD_TR_BIT 10
`define RTCB_CMD_SA_HI 9
`define RTCB_CMD_SA_LO 5
`define RTCB_SA_MODE_LO 5'h00
`define RTCB_SA_MODE_HI 5'h1F
`define RTCB_RT_BROADCAST_FLAG 5'h1F

`endif

//--- hdl/rtcb_pkg.sv
// Types shared by the ring buffer design files
package rtcb_pkg;
  typedef enum logic [2:0] {
    RTCB_IDLE,
    RTCB_DESC,
    RTCB_DATA,
    RTCB_SKIP,
    RTCB_POST_INFO,
    RTCB_POST_TT,
    RTCB_POST_CA
  } rtcb_state_type;
  typedef logic [15:0] rtcb_word_type;
endpackage

//--- hdl/rtcb_pipe2.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module rtcb_pipe2 #(
  parameter int WIDTH = 16
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  logic [WIDTH-1:0] mem_q [2];
  logic wr_idx_q;
  logic rd_idx_q;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic in_fire;
  logic out_fire;

  assign in_fire = in_valid && in_ready;
  assign out_fire = out_valid && out_ready;
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rd_idx_q];

  always_comb begin
    cnt_d = cnt_q;
    if (in_fire && !out_fire) begin
      cnt_d = cnt_q + 2'h1;
    end else if (out_fire && !in_fire) begin
      cnt_d = cnt_q - 2'h1;
    end
  end

  // Ready is registered so the source never sees a combinational path
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 2'h0;
      in_ready <= 1'b0;
      wr_idx_q <= 1'b0;
      rd_idx_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      in_ready <= (cnt_d != 2'h2);
      if (in_fire) begin
        wr_idx_q <= !wr_idx_q;
      end
      if (out_fire) begin
        rd_idx_q <= !rd_idx_q;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (in_fire) begin
      mem_q[wr_idx_q] <= in_data;
    end
  end
endmodule
`default_nettype wire

//--- hdl/rtcb_ring.sv
// Circular ring buffer mode one engine of the remote terminal
`timescale 1ns/1ns
`default_nettype none
`include "rtcb_cfg.svh"
module rtcb_ring
  import rtcb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_word,
  input wire logic rx_valid,
  input wire logic [15:0] rx_data,
  output logic rx_ready,
  input wire logic tx_req,
  output logic tx_valid,
  output logic [15:0] tx_data,
  input wire logic msg_done,
  input wire logic msg_error,
  input wire logic msg_busy,
  input wire logic msg_illegal,
  input wire logic [15:0] msg_info,
  input wire logic [15:0] msg_ttag,
  output logic ram_req,
  output logic ram_we,
  output logic [15:0] ram_addr,
  output logic [15:0] ram_wdata,
  input wire logic ram_ack,
  input wire logic [15:0] ram_rdata,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic ring_active,
  output logic host_irq_out
);
  // ****************************************
  // Declarations
  // ****************************************
  rtcb_state_type state_q;
  rtcb_word_type irq_en_q;
  rtcb_word_type config_q;
  rtcb_word_type ext_q;
  rtcb_word_type cmd_q;
  rtcb_word_type desc_q;
  rtcb_word_type ctrl_q;
  rtcb_word_type start_q;
  rtcb_word_type cur_q;
  rtcb_word_type end_q;
  rtcb_word_type ptr_q;
  rtcb_word_type info_q;
  rtcb_word_type ttag_q;
  rtcb_word_type next_ca_d;
  logic [1:0] idx_q;
  logic done_q;
  logic good_q;
  logic tx_pend_q;
  logic wrap_q;
  logic wrap_d;
  logic buf_valid;
  logic buf_ready;
  logic [15:0] buf_data;
  logic cmd_mode_code;
  logic cmd_broadcast_flag_tx;
  logic ring_sel;
  rtcb_word_type cmd_desc;

  // ****************************************
  // Receive word buffer
  // ****************************************
  // A stall while the RAM is busy holds words here, none are dropped
  rtcb_pipe2 #(
    .WIDTH(16)
  ) u_rx_buf (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .in_valid(rx_valid),
    .in_data(rx_data),
    .in_ready(rx_ready),
    .out_valid(buf_valid),
    .out_data(buf_data),
    .out_ready(buf_ready)
  );

  // Nothing drains before the pointer is loaded, else the first word is lost
  assign buf_ready = ((state_q == RTCB_DATA) && ring_active && !ram_req) ||
    (state_q == RTCB_SKIP);

  // ****************************************
  // Command decode
  // ****************************************
  assign cmd_mode_code =
    (cmd_word[`RTCB_CMD_SA_HI:`RTCB_CMD_SA_LO] == `RTCB_SA_MODE_LO) ||
    (cmd_word[`RTCB_CMD_SA_HI:`RTCB_CMD_SA_LO] == `RTCB_SA_MODE_HI);
  // Word count never changes a subaddress block, so it drops out of the index
  assign cmd_desc = `RTCB_DESC_BASE + {8'h00, cmd_word[`RTCB_CMD_TR_BIT],
    cmd_word[`RTCB_CMD_SA_HI:`RTCB_CMD_SA_LO], 2'h0};
  assign cmd_broadcast_flag_tx = cmd_q[`RTCB_CMD_TR_BIT] &&
    (cmd_q[`RTCB_CMD_RT_HI:`RTCB_CMD_RT_LO] == `RTCB_RT_BROADCAST_FLAG);
  assign ring_sel = !ctrl_q[`RTCB_CW_PINGPONG_BIT] && !ctrl_q[`RTCB_CW_MODE2_BIT] &&
    ctrl_q[`RTCB_CW_MODE1_BIT];

  // ****************************************
  // Host registers
  // ****************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_en_q <= `RTCB_REG_RESET;
      config_q <= `RTCB_REG_RESET;
      ext_q <= `RTCB_REG_RESET;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `RTCB_REG_IRQ_EN: irq_en_q <= reg_wdata;
        `RTCB_REG_CONFIG: config_q <= reg_wdata;
        `RTCB_REG_EXT: ext_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= `RTCB_REG_RESET;
    end else begin
      // Unmapped addresses read as zero
      unique case (reg_addr)
        `RTCB_REG_IRQ_EN: reg_rdata <= irq_en_q;
        `RTCB_REG_CONFIG: reg_rdata <= config_q;
        `RTCB_REG_EXT: reg_rdata <= ext_q;
        default: reg_rdata <= `RTCB_REG_RESET;
      endcase
    end
  end

  // ****************************************
  // Post-processing pointer decision
  // ****************************************
  // Separation config is not consulted: one ring serves both kinds
  always_comb begin
    next_ca_d = cur_q;
    wrap_d = 1'b0;
    if (good_q && !cmd_broadcast_flag_tx) begin
      // Overrun past the end pointer is allowed, the wrap is judged only here
      if (ptr_q > end_q) begin
        next_ca_d = start_q;
        wrap_d = 1'b1;
      end else begin
        next_ca_d = ptr_q;
      end
    end
  end

  // ****************************************
  // Message sequencer and RAM master
  // ****************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= RTCB_IDLE;
      ram_req <= 1'b0;
      ram_we <= 1'b0;
      ram_addr <= 16'h0000;
      ram_wdata <= 16'h0000;
      cmd_q <= 16'h0000;
      desc_q <= 16'h0000;
      ctrl_q <= 16'h0000;
      start_q <= 16'h0000;
      cur_q <= 16'h0000;
      end_q <= 16'h0000;
      ptr_q <= 16'h0000;
      idx_q <= 2'h0;
      wrap_q <= 1'b0;
      ring_active <= 1'b0;
    end else begin
      wrap_q <= 1'b0;
      unique case (state_q)
        RTCB_IDLE: begin
          if (cmd_valid) begin
            cmd_q <= cmd_word;
            desc_q <= cmd_desc;
            idx_q <= `RTCB_DW_CTRL;
            if (cmd_mode_code) begin
              state_q <= RTCB_SKIP;
            end else begin
              ram_req <= 1'b1;
              ram_we <= 1'b0;
              ram_addr <= cmd_desc;
              state_q <= RTCB_DESC;
            end
          end
        end
        RTCB_DESC: begin
          if (ram_ack) begin
            unique case (idx_q)
              `RTCB_DW_CTRL: ctrl_q <= ram_rdata;
              `RTCB_DW_START: start_q <= ram_rdata;
              `RTCB_DW_CUR: cur_q <= ram_rdata;
              `RTCB_DW_END: end_q <= ram_rdata;
            endcase
            if (idx_q == `RTCB_DW_END) begin
              ram_req <= 1'b0;
              state_q <= RTCB_DATA;
            end else begin
              idx_q <= idx_q + 2'h1;
              ram_addr <= desc_q + {14'h0000, idx_q + 2'h1};
            end
          end
        end
        RTCB_DATA: begin
          if (!ring_active && ram_req == 1'b0 && ptr_q == 16'h0000 && !ring_sel) begin
            // Another buffering scheme owns this subaddress
            state_q <= RTCB_SKIP;
          end else if (!ring_active) begin
            ring_active <= 1'b1;
            ptr_q <= cur_q + `RTCB_OFS_DATA;
          end else if (ram_req) begin
            if (ram_ack) begin
              ram_req <= 1'b0;
            end
          end else if (buf_valid) begin
            ram_req <= 1'b1;
            ram_we <= 1'b1;
            ram_addr <= ptr_q;
            ram_wdata <= buf_data;
            ptr_q <= ptr_q + `RTCB_STEP;
          end else if (tx_pend_q) begin
            ram_req <= 1'b1;
            ram_we <= 1'b0;
            ram_addr <= ptr_q;
            ptr_q <= ptr_q + `RTCB_STEP;
          end else if (done_q) begin
            ram_req <= 1'b1;
            ram_we <= 1'b1;
            ram_addr <= cur_q;
            ram_wdata <= info_q;
            state_q <= RTCB_POST_INFO;
          end
        end
        RTCB_SKIP: begin
          if (done_q) begin
            state_q <= RTCB_IDLE;
          end
        end
        RTCB_POST_INFO: begin
          if (ram_ack) begin
            ram_addr <= cur_q + `RTCB_OFS_TTAG;
            ram_wdata <= ttag_q;
            state_q <= RTCB_POST_TT;
          end
        end
        RTCB_POST_TT: begin
          if (ram_ack) begin
            // Only the current pointer word of the descriptor is rewritten
            ram_addr <= desc_q + {14'h0000, `RTCB_DW_CUR};
            ram_wdata <= next_ca_d;
            cur_q <= next_ca_d;
            wrap_q <= wrap_d;
            state_q <= RTCB_POST_CA;
          end
        end
        RTCB_POST_CA: begin
          if (ram_ack) begin
            ram_req <= 1'b0;
            ram_we <= 1'b0;
            ring_active <= 1'b0;
            ptr_q <= 16'h0000;
            state_q <= RTCB_IDLE;
          end
        end
      endcase
      if (state_q == RTCB_IDLE) begin
        ring_active <= 1'b0;
        ptr_q <= 16'h0000;
      end
    end
  end

  // ****************************************
  // Transmit request latch
  // ****************************************
  // Request set wins over the clear at issue; requests pending together merge
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_pend_q <= 1'b0;
    end else begin
      if (tx_req) begin
        tx_pend_q <= 1'b1;
      end else if (state_q == RTCB_DATA && ring_active && !ram_req && !buf_valid) begin
        tx_pend_q <= 1'b0;
      end else if (state_q == RTCB_IDLE) begin
        tx_pend_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Message completion capture
  // ****************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      done_q <= 1'b0;
      good_q <= 1'b0;
      info_q <= 16'h0000;
      ttag_q <= 16'h0000;
    end else begin
      if (msg_done) begin
        done_q <= 1'b1;
        good_q <= !(msg_error || msg_busy || msg_illegal);
        info_q <= msg_info;
        info_q[`RTCB_INFO_BROADCAST_FLAG_BIT] <= ext_q[`RTCB_EXT_BROADCAST_FLAG_BIT] &&
          (cmd_q[`RTCB_CMD_RT_HI:`RTCB_CMD_RT_LO] == `RTCB_RT_BROADCAST_FLAG);
        ttag_q <= msg_ttag;
      end else if (state_q == RTCB_IDLE || state_q == RTCB_POST_INFO) begin
        done_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Transmit word return
  // ****************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_valid <= 1'b0;
      tx_data <= 16'h0000;
    end else begin
      tx_valid <= (state_q == RTCB_DATA) && ram_req && ram_ack && !ram_we;
      if ((state_q == RTCB_DATA) && ram_ack && !ram_we) begin
        tx_data <= ram_rdata;
      end
    end
  end

  // ****************************************
  // Full or empty notification
  // ****************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      host_irq_out <= 1'b0;
    end else begin
      host_irq_out <= wrap_q && ctrl_q[`RTCB_CW_BLKDONE_BIT] &&
        irq_en_q[`RTCB_IE_BLKDONE_BIT];
    end
  end
endmodule
`default_nettype wire

//--- testbench/rtcb_ram_model.sv
// Shared RAM model answering the ring engine's word accesses
`timescale 1ns/1ns
`default_nettype none
module rtcb_ram_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [3:0] lat,
  input wire logic ram_req,
  input wire logic ram_we,
  input wire logic [15:0] ram_addr,
  input wire logic [15:0] ram_wdata,
  output logic ram_ack,
  output logic [15:0] ram_rdata
);
  // ****************************************
  // Storage and handshake
  // ****************************************
  logic [15:0] mem [0:4095];
  logic [15:0] rd_q = 16'h0000;
  logic [3:0] wait_q = 4'h0;
  // Outside the ack cycle the read bus carries a scrambled word, never stale data
  assign ram_rdata = ram_ack ? rd_q : ~rd_q;
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ram_ack <= 1'b0;
      wait_q <= 4'h0;
    end else begin
      ram_ack <= 1'b0;
      if (ram_req && !ram_ack) begin
        if (wait_q >= lat) begin
          ram_ack <= 1'b1;
          wait_q <= 4'h0;
          rd_q <= mem[ram_addr[11:0]];
          if (ram_we) begin
            mem[ram_addr[11:0]] <= ram_wdata;
          end
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- testbench/rtcb_ring_properties.sv
// Concurrent checks on the ring engine ports
`timescale 1ns/1ns
`default_nettype none
module rtcb_ring_chk (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_word,
  input wire logic tx_req,
  input wire logic tx_valid,
  input wire logic msg_done,
  input wire logic ram_req,
  input wire logic ram_we,
  input wire logic [15:0] ram_addr,
  input wire logic ram_ack,
  input wire logic ring_active,
  input wire logic host_irq_out
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic idle_cmd;
  logic mode_sa;
  assign idle_cmd = cmd_valid && !ram_req && !ring_active;
  assign mode_sa = (cmd_word[9:5] == 5'h00) || (cmd_word[9:5] == 5'h1F);
  property p_desc_read;
    idle_cmd && !mode_sa |=> ram_req && !ram_we && ram_addr == {8'h04, $past(cmd_word[10:5]), 2'h0};
  endproperty
  a_desc_read: assert property (p_desc_read) else $error("descriptor read misplaced");
  property p_desc_seq;
    ram_req && ram_ack && !ram_we && ram_addr[15:8] == 8'h04 && ram_addr[1:0] != 2'h3
      |=> ram_req && ram_addr == $past(ram_addr) + 16'h0001;
  endproperty
  a_desc_seq: assert property (p_desc_seq) else $error("descriptor words out of order");
  property p_ptr_write;
    ram_req && ram_we && ram_addr[15:8] == 8'h04 |-> ram_addr[1:0] == 2'h2;
  endproperty
  a_ptr_write: assert property (p_ptr_write) else $error("static pointer rewritten");
  property p_post_write;
    msg_done && ring_active |-> ##[1:300] ram_req && ram_we && ram_addr[15:8] == 8'h04;
  endproperty
  a_post_write: assert property (p_post_write) else $error("no pointer write back");
  property p_irq_pulse;
    host_irq_out |=> !host_irq_out;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt longer than a pulse");
  property p_irq_cause;
    host_irq_out |-> $past(ram_ack, 2) && $past(ram_we, 2);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt not after a write");
  property p_mode_skip;
    idle_cmd && mode_sa |=> !ring_active [*8];
  endproperty
  a_mode_skip: assert property (p_mode_skip) else $error("mode code entered ring");
  property p_tx_answer;
    tx_req && ring_active |-> ##[3:80] tx_valid;
  endproperty
  a_tx_answer: assert property (p_tx_answer) else $error("transmit word late");
  property p_tx_read;
    tx_valid |-> $past(ram_ack) && !$past(ram_we);
  endproperty
  a_tx_read: assert property (p_tx_read) else $error("transmit word without read");
endmodule
bind rtcb_ring rtcb_ring_chk u_chk (
  .ref_clk(ref_clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
  .tx_req(tx_req), .tx_valid(tx_valid), .msg_done(msg_done), .ram_req(ram_req),
  .ram_we(ram_we), .ram_addr(ram_addr), .ram_ack(ram_ack), .ring_active(ring_active),
  .host_irq_out(host_irq_out)
);
`default_nettype wire

//--- testbench/rtcb_ring_tb.sv
// Self-checking bench of the ring engine with a RAM model
`timescale 1ns/1ns
`default_nettype none
module rtcb_ring_tb;
  // ****************************************
  // Stimulus and checks
  // ****************************************
  logic ref_clk = 1'b0, nrst = 1'b0, cmd_valid = 1'b0, rx_valid = 1'b0, tx_req = 1'b0;
  logic msg_done = 1'b0, reg_wr = 1'b0, msg_error = 1'b0, msg_busy = 1'b0, msg_illegal = 1'b0;
  logic [15:0] cmd_word = 16'h0000, rx_data = 16'h0000, msg_info = 16'h0000;
  logic [15:0] msg_ttag = 16'h0000, reg_wdata = 16'h0000, tt = 16'h7100;
  logic [7:0] reg_addr = 8'h00;
  logic [3:0] lat = 4'h0;
  logic rx_ready, tx_valid, ram_req, ram_we, ram_ack, ring_active, host_irq_out;
  logic [15:0] tx_data, ram_addr, ram_wdata, ram_rdata, reg_rdata;
  int n_mismatch = 0, total_checks = 0, wd = 0, irq_n = 0, i;
  logic [7:0] ra [4] = '{8'h12, 8'h17, 8'h4D, 8'h20};
  logic [15:0] rv [4] = '{16'h8000, 16'hFFFF, 16'h0008, 16'h1234};
  logic [15:0] cws [2] = '{16'h8003, 16'h8006};
  rtcb_ring uut (.*);
  rtcb_ram_model mdl (.*);
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (host_irq_out === 1'b1) begin
      irq_n++;
    end
  end
  task conclude();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Every wait is bounded so a hung engine still reaches the verdict
  task step();
    @(posedge ref_clk);
    wd++;
    if (wd > 3000) begin
      n_mismatch++;
      conclude();
    end
  endtask
  task wreg(input logic [7:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task rreg(input logic [7:0] a, input logic [15:0] e);
    reg_addr <= a;
    repeat (2) @(posedge ref_clk);
    check("reg_rdata", e, reg_rdata);
  endtask
  task desc(input logic [11:0] n, input logic [15:0] cw, input logic [15:0] sa,
            input logic [15:0] ea);
    mdl.mem[n] = cw;
    mdl.mem[n + 12'h001] = sa;
    mdl.mem[n + 12'h002] = sa;
    mdl.mem[n + 12'h003] = ea;
  endtask
  task rec(input logic [11:0] a, input logic bc, input logic [15:0] ca, input logic [11:0] n);
    check("info", {6'h02, bc, 9'h05A}, mdl.mem[a]);
    check("ttag", tt, mdl.mem[a + 12'h001]);
    check("cur_ptr", ca, mdl.mem[n + 12'h002]);
  endtask
  task rxd(input logic [11:0] a, input int n);
    int k;
    for (k = 0; k < n; k++) begin
      check("rx_word", 16'hD000 + 16'(k), mdl.mem[a + 12'(k)]);
    end
  endtask
  task msg(input logic [15:0] cmd, input int n, input logic [1:0] kind, input logic [15:0] ca);
    int k;
    int quiet;
    cmd_word <= cmd;
    cmd_valid <= 1'b1;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    for (k = 0; k < n; k++) begin
      if (cmd[10]) begin
        wd = 0;
        while (ring_active !== 1'b1) step();
        tx_req <= 1'b1;
        @(posedge ref_clk);
        tx_req <= 1'b0;
        wd = 0;
        do step(); while (tx_valid !== 1'b1);
        check("tx_data", 16'hE002 + ca + 16'(k), tx_data);
      end else begin
        rx_valid <= 1'b1;
        rx_data <= 16'hD000 + 16'(k);
        wd = 0;
        do step(); while (rx_ready !== 1'b1);
      end
    end
    rx_valid <= 1'b0;
    tt = tt + 16'h0001;
    msg_done <= 1'b1;
    msg_error <= (kind == 2'h1);
    msg_busy <= (kind == 2'h2);
    msg_illegal <= (kind == 2'h3);
    msg_info <= 16'h0A5A;
    msg_ttag <= tt;
    @(posedge ref_clk);
    msg_done <= 1'b0;
    repeat (2) @(posedge ref_clk);
    // The end of the descriptor fetch leaves a one-cycle gap; wait for a settled idle
    wd = 0;
    quiet = 0;
    while (quiet < 2) begin
      step();
      quiet = (ring_active === 1'b0 && ram_req === 1'b0) ? quiet + 1 : 0;
    end
    repeat (2) @(posedge ref_clk);
  endtask
  initial begin
    // Untouched words keep this pattern, which also serves as transmit data
    for (i = 0; i < 4096; i++) begin
      mdl.mem[i] = 16'hE000 + 16'(i);
    end
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    for (i = 0; i < 4; i++) begin
      rreg(ra[i], 16'h0000);
    end
    for (i = 0; i < 4; i++) begin
      wreg(ra[i], rv[i]);
      rreg(ra[i], (i == 3) ? 16'h0000 : rv[i]);
    end
    desc(12'h404, 16'h8002, 16'h0100, 16'h0105);
    desc(12'h488, 16'h8002, 16'h0200, 16'h0210);
    desc(12'h400, 16'h8002, 16'h0300, 16'h0310);
    msg(16'h0823, 3, 2'h0, 16'h0100);
    rxd(12'h102, 3);
    rec(12'h100, 1'b0, 16'h0105, 12'h404);
    check("irq", 16'h0000, 16'(irq_n));
    lat <= 4'h3;
    msg(16'h0823, 3, 2'h0, 16'h0105);
    rxd(12'h107, 3);
    rec(12'h105, 1'b0, 16'h0100, 12'h404);
    check("irq", 16'h0001, 16'(irq_n));
    for (i = 1; i < 4; i++) begin
      msg(16'h0821, 1, 2'(i), 16'h0100);
      rec(12'h100, 1'b0, 16'h0100, 12'h404);
    end
    msg(16'hF822, 2, 2'h0, 16'h0100);
    rxd(12'h102, 2);
    rec(12'h100, 1'b1, 16'h0104, 12'h404);
    msg(16'h0C42, 2, 2'h0, 16'h0200);
    rec(12'h200, 1'b0, 16'h0204, 12'h488);
    msg(16'hFC42, 0, 2'h0, 16'h0204);
    rec(12'h204, 1'b1, 16'h0204, 12'h488);
    mdl.mem[12'h48B] = 16'h0207;
    msg(16'h0C42, 2, 2'h0, 16'h0204);
    rec(12'h204, 1'b0, 16'h0200, 12'h488);
    check("irq", 16'h0002, 16'(irq_n));
    wreg(8'h12, 16'h0000);
    // Host refills the words that the last records took before sending again
    mdl.mem[12'h204] = 16'hE204;
    mdl.mem[12'h205] = 16'hE205;
    msg(16'h0C46, 6, 2'h0, 16'h0200);
    check("irq", 16'h0002, 16'(irq_n));
    check("start_ptr", 16'h0100, mdl.mem[12'h405]);
    check("end_ptr", 16'h0207, mdl.mem[12'h48B]);
    msg(16'h0803, 1, 2'h0, 16'h0300);
    check("mode_code", 16'hE300, mdl.mem[12'h300]);
    for (i = 0; i < 2; i++) begin
      desc(12'h40C, cws[i], 16'h0380, 16'h0390);
      msg(16'h0861, 1, 2'h0, 16'h0380);
      check("non_ring", 16'hE380, mdl.mem[12'h380]);
    end
    conclude();
  end
endmodule
`default_nettype wire
